// file: bench/asbl_host_props.sv
// Checker for the host-side pin sequencing of the SRAM port
`timescale 1ns/10ps
`default_nettype none
`include "asbl_defs.svh"
module asbl_host_props (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Memory pins as driven by the host
    input wire logic [`ASBL_ADDR_W-1:0] o_mem_addr,
    input wire logic o_chip_select_n,
    input wire logic o_write_strobe_n,
    input wire logic o_output_enable_n,
    input wire logic o_lower_lane_enable_n,
    input wire logic o_upper_lane_enable_n,
    input wire logic [`ASBL_DATA_W-1:0] o_mem_data,
    input wire logic [`ASBL_DATA_W-1:0] o_mem_data_oe
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    // Strobe low two cycles, then released
    sequence s_strobe;
        !o_write_strobe_n [*2] ##1 o_write_strobe_n;
    endsequence
    a_strobe_len: assert property (
        $fell(o_write_strobe_n) |-> s_strobe) else $error("strobe width");
    a_write_overlap: assert property (
        !o_write_strobe_n |-> !o_chip_select_n &&
        !(o_lower_lane_enable_n && o_upper_lane_enable_n))
        else $error("strobe without select or lane");
    a_no_strobe_read: assert property (
        !o_output_enable_n |-> o_write_strobe_n) else $error("strobe in read");
    a_addr_held: assert property (
        !o_chip_select_n && !$past(o_chip_select_n) |-> $stable(o_mem_addr))
        else $error("address moved while selected");
    a_data_held: assert property (
        !o_write_strobe_n && !$past(o_write_strobe_n) |-> $stable(o_mem_data))
        else $error("write data moved");
    a_drive_turn: assert property (
        |o_mem_data_oe |-> !o_write_strobe_n && o_output_enable_n)
        else $error("host drives outside strobe");
    a_release_same: assert property (
        $rose(o_write_strobe_n) |-> o_chip_select_n)
        else $error("select held after strobe");
endmodule
`default_nettype wire

// file: bench/asbl_host_tb.sv
// Testbench for the SRAM host controller
`timescale 1ns/10ps
`default_nettype none
module asbl_host_tb;
    typedef struct packed {
        logic w; logic [17:0] a; logic [15:0] d; logic [1:0] l;
        logic [15:0] e;
    } asbl_row_t;
    asbl_row_t rows [9] = '{
        '{1'b1, 18'h00000, 16'h1234, 2'h3, 16'h0000},
        '{1'b0, 18'h00000, 16'h0000, 2'h3, 16'h1234},
        '{1'b1, 18'h00000, 16'hABCD, 2'h1, 16'h0000},
        '{1'b0, 18'h00000, 16'h0000, 2'h2, 16'h1200},
        '{1'b1, 18'h00000, 16'hEF99, 2'h2, 16'h0000},
        '{1'b0, 18'h00000, 16'h0000, 2'h1, 16'h00CD},
        '{1'b0, 18'h00000, 16'h0000, 2'h3, 16'hEFCD},
        '{1'b1, 18'h3FFFF, 16'h5A5A, 2'h3, 16'h0000},
        '{1'b0, 18'h3FFFF, 16'h0000, 2'h3, 16'h5A5A}};
    logic clk = 1'b0, rst_n = 1'b0, req = 1'b0, wr = 1'b0;
    logic [17:0] addr = 18'h00000, maddr;
    logic [15:0] wdata = 16'h0000, rdata, hq, hoe, dq, doe, din;
    logic [15:0] fill = 16'h5A5A; // Undriven lines toggle each cycle
    logic [1:0] lane = 2'h0;
    logic busy, done, cs_n, we_n, oe_n, lo_n, hi_n;
    int n_fail = 0, n_tests = 0;
    initial forever #20 clk = ~clk;
    always @(posedge clk) fill <= ~fill;
    // Wire level: host, then device, else floating pattern
    assign #1 din = (hoe & hq) | (~hoe & doe & dq) | (~hoe & ~doe & fill);
    asbl_host dut_u (.i_ref_clk(clk), .i_rst_n(rst_n), .i_req(req),
        .i_write(wr), .i_addr(addr), .i_wdata(wdata), .i_lane_en(lane),
        .o_busy(busy), .o_done(done), .o_rdata(rdata), .o_mem_addr(maddr),
        .o_chip_select_n(cs_n), .o_write_strobe_n(we_n),
        .o_output_enable_n(oe_n), .o_lower_lane_enable_n(lo_n),
        .o_upper_lane_enable_n(hi_n), .i_mem_data(din), .o_mem_data(hq),
        .o_mem_data_oe(hoe));
    asbl_sram_model mem_u (.i_addr(maddr), .i_cs_n(cs_n), .i_we_n(we_n),
        .i_oe_n(oe_n), .i_lo_n(lo_n), .i_hi_n(hi_n), .i_dq(din), .o_q(dq),
        .o_q_oe(doe));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("Checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // One request, then a bounded wait for completion
    task automatic access(input asbl_row_t r);
        int k;
        @(posedge clk); #1;
        {req, wr, addr, wdata, lane} = {1'b1, r.w, r.a, r.d, r.l};
        @(posedge clk); #1;
        req = 1'b0;
        for (k = 0; k < 20 && done !== 1'b1; k++) begin
            @(posedge clk); #1;
        end
        if (k == 20) begin
            n_fail++;
            results();
        end
    endtask
    initial begin
        repeat (5) @(posedge clk);
        #1 rst_n = 1'b1;
        foreach (rows[i]) begin
            access(rows[i]);
            if (!rows[i].w) check(rdata, rows[i].e);
        end
        // Empty lane mask is ignored
        @(posedge clk); #1 {req, lane} = 3'b100;
        @(posedge clk); #1 req = 1'b0;
        @(posedge clk); #1 check({14'h0, busy, cs_n}, 16'h0001);
        // Reset between accesses: pins idle, contents kept
        rst_n = 1'b0;
        #1 check({11'h0, cs_n, we_n, oe_n, lo_n, hi_n}, 16'h001F);
        check(hoe, 16'h0000);
        @(posedge clk); #1 rst_n = 1'b1;
        access(rows[8]);
        check(rdata, 16'h5A5A);
        results();
    end
endmodule
bind asbl_host asbl_host_props props_u (.i_ref_clk, .i_rst_n, .o_mem_addr,
    .o_chip_select_n, .o_write_strobe_n, .o_output_enable_n,
    .o_lower_lane_enable_n, .o_upper_lane_enable_n, .o_mem_data,
    .o_mem_data_oe);
`default_nettype wire

// file: bench/asbl_sram_model.sv
// Behavioural model of the 256K x 16 static memory
`timescale 1ns/10ps
`default_nettype none
module asbl_sram_model (
    // Pins from the host
    input wire logic [17:0] i_addr,
    input wire logic i_cs_n,
    input wire logic i_we_n,
    input wire logic i_oe_n,
    input wire logic i_lo_n,
    input wire logic i_hi_n,
    input wire logic [15:0] i_dq,
    // Data driven back, with per-bit enable
    output logic [15:0] o_q,
    output logic [15:0] o_q_oe
);
    logic [15:0] mem [0:262143]; // Word array, two lanes
    logic rd; // Read decode
    logic [1:0] ln; // Lane enables, active high
    assign ln = {~i_hi_n, ~i_lo_n};
    // Drive only enabled lanes in a read
    assign rd = ~i_cs_n & i_we_n & ~i_oe_n;
    assign o_q_oe = {{8{rd & ln[1]}}, {8{rd & ln[0]}}};
    assign o_q = mem[i_addr];
    // Store during the overlap only
    always @* begin
        if (!i_cs_n && !i_we_n && ln[0]) mem[i_addr][7:0] = i_dq[7:0];
        if (!i_cs_n && !i_we_n && ln[1]) mem[i_addr][15:8] = i_dq[15:8];
    end // Other lane kept
endmodule
`default_nettype wire

// file: design/asbl_host.sv
// Host controller driving an async 16-bit SRAM with byte lanes
`timescale 1ns/10ps
`default_nettype none
`include "asbl_defs.svh"
module asbl_host (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // User request side
    input wire logic i_req,
    input wire logic i_write,
    input wire logic [`ASBL_ADDR_W-1:0] i_addr,
    input wire logic [`ASBL_DATA_W-1:0] i_wdata,
    input wire logic [1:0] i_lane_en,
    output logic o_busy,
    output logic o_done,
    output logic [`ASBL_DATA_W-1:0] o_rdata,
    // Memory pins, strobes active low
    output logic [`ASBL_ADDR_W-1:0] o_mem_addr,
    output logic o_chip_select_n,
    output logic o_write_strobe_n,
    output logic o_output_enable_n,
    output logic o_lower_lane_enable_n,
    output logic o_upper_lane_enable_n,
    // Data pins as three signals
    input wire logic [`ASBL_DATA_W-1:0] i_mem_data,
    output logic [`ASBL_DATA_W-1:0] o_mem_data,
    output logic [`ASBL_DATA_W-1:0] o_mem_data_oe
);
    asbl_pkg::asbl_state_t state; // Current state
    asbl_pkg::asbl_state_t next_state; // Next state
    logic [`ASBL_CNT_W-1:0] cnt; // Strobe width counter
    logic is_write; // Latched direction
    logic [1:0] lanes; // Latched lane enables
    logic [`ASBL_DATA_W-1:0] data_sync; // Synchronised read data

    // Lane mask expanded to a bit mask
    function automatic logic [`ASBL_DATA_W-1:0] lane_mask(
        input logic [1:0] l);
        lane_mask = {{`ASBL_LANE_W{l[1]}}, {`ASBL_LANE_W{l[0]}}};
    endfunction

    // Read data passes two flops before use
    asbl_sync #(.WIDTH(`ASBL_DATA_W)) u_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_async(i_mem_data),
        .o_sync(data_sync)
    );

    // Decode of request and timing
    wire start = (state == asbl_pkg::ASBL_IDLE) && i_req &&
        (i_lane_en != 2'b00); // Empty lane requests are dropped
    wire [`ASBL_CNT_W-1:0] strobe_len = is_write ?
        `ASBL_CNT_W'(`ASBL_WR_CYC) :
        `ASBL_CNT_W'(`ASBL_RD_CYC + 2);
    wire strobe_end = (state == asbl_pkg::ASBL_STROBE) &&
        (cnt == strobe_len - `ASBL_CNT_W'(1));
    wire [`ASBL_DATA_W-1:0] rd_mask = lane_mask(lanes);

    // Next state selection
    always_comb begin
        next_state = state;
        case (state)
            asbl_pkg::ASBL_IDLE: begin
                if (start) begin
                    next_state = asbl_pkg::ASBL_SETUP;
                end
            end
            asbl_pkg::ASBL_SETUP: begin
                next_state = asbl_pkg::ASBL_STROBE;
            end
            asbl_pkg::ASBL_STROBE: begin
                if (strobe_end) begin
                    next_state = asbl_pkg::ASBL_RELEASE;
                end
            end
            asbl_pkg::ASBL_RELEASE: begin
                next_state = asbl_pkg::ASBL_IDLE;
            end
            default: begin
                next_state = asbl_pkg::ASBL_IDLE;
            end
        endcase
    end

    // State and counter
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= asbl_pkg::ASBL_IDLE;
            cnt <= '0;
        end else begin
            state <= next_state;
            cnt <= (state == asbl_pkg::ASBL_STROBE) ?
                cnt + `ASBL_CNT_W'(1) : '0;
        end
    end

    // Request capture and address, held for whole access
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            is_write <= 1'b0;
            lanes <= 2'b00;
            o_mem_addr <= '0;
            o_mem_data <= '0;
        end else if (start) begin
            is_write <= i_write;
            lanes <= i_lane_en;
            o_mem_addr <= i_addr; // Address set on the same edge as select
            o_mem_data <= i_wdata; // Stable through end edge
        end
    end

    // Strobes: select and lanes span setup and strobe, lanes from the prior request in setup
    wire sel_on = (next_state == asbl_pkg::ASBL_SETUP) ||
        (next_state == asbl_pkg::ASBL_STROBE);
    // Write strobe only inside select, never on reads
    wire we_on = (next_state == asbl_pkg::ASBL_STROBE) && is_write;
    // Output enable from latched direction, so a write after a read or reset still enables output in setup
    wire oe_on = sel_on && !is_write;
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_chip_select_n <= 1'b1;
            o_write_strobe_n <= 1'b1;
            o_output_enable_n <= 1'b1;
            o_lower_lane_enable_n <= 1'b1;
            o_upper_lane_enable_n <= 1'b1;
        end else begin
            o_chip_select_n <= !sel_on; // Deselect when idle
            o_write_strobe_n <= !we_on; // Ends on the same edge as select
            o_output_enable_n <= !oe_on;
            o_lower_lane_enable_n <= !(sel_on && lanes[0]);
            o_upper_lane_enable_n <= !(sel_on && lanes[1]);
        end
    end

    // Data drive: lanes being written, only while strobe low
    wire [`ASBL_DATA_W-1:0] next_oe = we_on ? rd_mask : '0;
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_mem_data_oe <= '0;
        end else begin
            o_mem_data_oe <= next_oe;
        end
    end

    // Read data capture at strobe end, unread lanes zero
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= '0;
            o_done <= 1'b0;
            o_busy <= 1'b0;
        end else begin
            o_done <= strobe_end;
            o_busy <= (next_state != asbl_pkg::ASBL_IDLE);
            if (strobe_end && !is_write) begin
                o_rdata <= data_sync & rd_mask;
            end
        end
    end
endmodule
`default_nettype wire

// file: design/asbl_sync.sv
// Two-flop synchroniser for the returning data pins
`timescale 1ns/10ps
`default_nettype none
module asbl_sync #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Asynchronous input and synchronised output
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta; // First stage, read only by second

    // Two stages in series
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta <= '0;
            o_sync <= '0;
        end else begin
            meta <= i_async;
            o_sync <= meta;
        end
    end
endmodule
`default_nettype wire

// file: pkg/asbl_defs.svh
// Constants for the async SRAM byte-lane host controller
`ifndef ASBL_DEFS_SVH
`define ASBL_DEFS_SVH
`define ASBL_ADDR_W 18
`define ASBL_DATA_W 16
`define ASBL_LANE_W 8
`define ASBL_CLK_PERIOD_NS 40
// Read and write timing figures, slower grade
`define ASBL_T_RC_NS 70
`define ASBL_T_AA_NS 70
`define ASBL_T_PWE_NS 60
`define ASBL_T_SD_NS 30
// Cycle counts, least times rounded up
`define ASBL_RD_CYC ((`ASBL_T_AA_NS+`ASBL_CLK_PERIOD_NS-1)/`ASBL_CLK_PERIOD_NS)
`define ASBL_WR_CYC ((`ASBL_T_PWE_NS+`ASBL_CLK_PERIOD_NS-1)/`ASBL_CLK_PERIOD_NS)
`define ASBL_CNT_W 3
`endif

// file: pkg/asbl_pkg.sv
// Types for the async SRAM byte-lane host controller
package asbl_pkg;
    // Controller states, Gray along idle-setup-strobe-release
    typedef enum logic [2:0] {
        ASBL_IDLE = 3'b000,
        ASBL_SETUP = 3'b001,
        ASBL_STROBE = 3'b011,
        ASBL_RELEASE = 3'b010
    } asbl_state_t;
endpackage
